// [bptr_params.svh]
// Register offsets, field layouts and timing constants for the buffer pointer and timer bank.
// Assumes APB with 32-bit data; printed offsets are register indices, byte address is four times.
`ifndef BPTR_PARAMS_SVH
`define BPTR_PARAMS_SVH

// ****************************************
// Register indices
// ****************************************
`define BPTR_IDX_SLA_HI 8'h3b
`define BPTR_IDX_SLA_MID 8'h3c
`define BPTR_IDX_SLA_LO 8'h3d
`define BPTR_IDX_CWP_HI 8'h3f
`define BPTR_IDX_CWP_MID 8'h40
`define BPTR_IDX_CWP_LO 8'h41
`define BPTR_IDX_CRP_HI 8'h43
`define BPTR_IDX_CRP_MID 8'h44
`define BPTR_IDX_CRP_LO 8'h45
`define BPTR_IDX_RBC_HI 8'h46
`define BPTR_IDX_RBC_LO 8'h47
`define BPTR_IDX_FR_HI 8'h48
`define BPTR_IDX_FR_LO 8'h49
`define BPTR_IDX_TMR_HI 8'h4a
`define BPTR_IDX_TMR_LO 8'h4b
`define BPTR_IDX_TSCALE 8'h4c
`define BPTR_IDX_SBA_HI 8'h4e
`define BPTR_IDX_SBA_LO 8'h4f
`define BPTR_IDX_CTRL 8'h60
`define BPTR_IDX_IRQ_STAT 8'h61
`define BPTR_IDX_IRQ_MASK 8'h62
`define BPTR_IDX_BLK_INC 8'h63

// ****************************************
// Fields and reset values
// ****************************************
`define BPTR_CTRL_END_LIMIT_BIT 1
`define BPTR_CTRL_SUBCODE_BIT 0
`define BPTR_IRQ_TIMER_BIT 0
`define BPTR_IRQ_STOP_BIT 1
`define BPTR_IRQ_WIDTH 2
`define BPTR_ADDR_W 20
`define BPTR_BLK_W 10
`define BPTR_RATIO_W 11
`define BPTR_AREA_W 9
`define BPTR_TICKS_PER_STEP 12'h010
`define BPTR_RESET_BYTE 8'h00

`endif

// [bptr_pkg.sv]
// Types shared by the buffer pointer and timer bank.
// Constants live in bptr_params.svh.
package bptr_pkg;
  typedef enum logic [1:0] {
    BPTR_TMR_IDLE = 2'b01,
    BPTR_TMR_RUN = 2'b10
  } bptr_tmr_state_t;
endpackage

// [bptr_regs.sv]
// Buffer pointer, block counter and one-shot timer register bank with an APB slave.
// Assumes one 50 MHz clock; buffer events arrive as one-cycle pulses synchronous to pclk.
// Notes on behaviour
// - With end-limit enabled in subcode mode, a write at last address stops buffering.
// - Each sub CPU buffer write advances the write pointer by one.
// - Each sub CPU buffer read advances the read pointer by one.
// - Ready block count is ten bits, preloaded by software before decoding.
// - While buffering is not stopped, a sector buffered with transfer flag adds the one-to-four block increment.
// - Each completed block transfer subtracts exactly one from the count.
// - Fill ratio is an eleven-bit readable and writable value.
// - After low byte write, interrupt fires after count times resolution period.
// - Resolution period is scale setting times sixteen clock cycles.
// - Read-only nine-bit stream begin area is exposed.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`include "bptr_params.svh"

module bptr_regs
  import bptr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cpu_buf_write,
  input wire logic cpu_buf_read,
  input wire logic buf_write,
  input wire logic [19:0] buf_write_addr,
  input wire logic sector_done,
  input wire logic sector_transfer_flag,
  input wire logic block_xfer_done,
  input wire logic [8:0] stream_begin_area,
  output logic [19:0] cpu_write_ptr,
  output logic [19:0] cpu_read_ptr,
  output logic [10:0] fill_ratio,
  output logic buffering_stop,
  output logic irq
);

  // ****************************************
  // APB decode
  // ****************************************
  wire logic access = psel && penable;
  wire logic wr_en = access && pwrite;
  wire logic [7:0] idx = paddr[9:2];
  wire logic [7:0] wb = pwdata[7:0];
  wire logic aligned = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);

  function automatic logic hit(input logic [7:0] i, input logic [7:0] want, input logic ok);
    hit = ok && (i == want);
  endfunction

  function automatic logic [19:0] inc20(input logic [19:0] v);
    inc20 = v + 20'h00001;
  endfunction

  wire logic w_sla_hi = wr_en && hit(idx, `BPTR_IDX_SLA_HI, aligned);
  wire logic w_sla_mid = wr_en && hit(idx, `BPTR_IDX_SLA_MID, aligned);
  wire logic w_sla_lo = wr_en && hit(idx, `BPTR_IDX_SLA_LO, aligned);
  wire logic w_cwp_hi = wr_en && hit(idx, `BPTR_IDX_CWP_HI, aligned);
  wire logic w_cwp_mid = wr_en && hit(idx, `BPTR_IDX_CWP_MID, aligned);
  wire logic w_cwp_lo = wr_en && hit(idx, `BPTR_IDX_CWP_LO, aligned);
  wire logic w_crp_hi = wr_en && hit(idx, `BPTR_IDX_CRP_HI, aligned);
  wire logic w_crp_mid = wr_en && hit(idx, `BPTR_IDX_CRP_MID, aligned);
  wire logic w_crp_lo = wr_en && hit(idx, `BPTR_IDX_CRP_LO, aligned);
  wire logic w_rbc_hi = wr_en && hit(idx, `BPTR_IDX_RBC_HI, aligned);
  wire logic w_rbc_lo = wr_en && hit(idx, `BPTR_IDX_RBC_LO, aligned);
  wire logic w_fr_hi = wr_en && hit(idx, `BPTR_IDX_FR_HI, aligned);
  wire logic w_fr_lo = wr_en && hit(idx, `BPTR_IDX_FR_LO, aligned);
  wire logic w_tmr_hi = wr_en && hit(idx, `BPTR_IDX_TMR_HI, aligned);
  wire logic w_tmr_lo = wr_en && hit(idx, `BPTR_IDX_TMR_LO, aligned);
  wire logic w_scale = wr_en && hit(idx, `BPTR_IDX_TSCALE, aligned);
  wire logic w_ctrl = wr_en && hit(idx, `BPTR_IDX_CTRL, aligned);
  wire logic w_stat = wr_en && hit(idx, `BPTR_IDX_IRQ_STAT, aligned);
  wire logic w_mask = wr_en && hit(idx, `BPTR_IDX_IRQ_MASK, aligned);
  wire logic w_inc = wr_en && hit(idx, `BPTR_IDX_BLK_INC, aligned);

  // ****************************************
  // Storage
  // ****************************************
  logic [3:0] sla_hi_r;
  logic [7:0] sla_mid_r;
  logic [19:0] sla_r;
  logic [3:0] cwp_hi_r;
  logic [7:0] cwp_mid_r;
  logic [19:0] cwp_r;
  logic [3:0] crp_hi_r;
  logic [7:0] crp_mid_r;
  logic [19:0] crp_r;
  logic [2:0] rbc_hi_r;
  logic [9:0] rbc_r;
  logic [2:0] fr_hi_r;
  logic [10:0] fr_r;
  logic [7:0] tmr_hi_r;
  logic [15:0] tmr_r;
  logic [7:0] scale_r;
  logic [1:0] ctrl_r;
  logic [1:0] blk_inc_r;
  logic [`BPTR_IRQ_WIDTH-1:0] stat_r;
  logic [`BPTR_IRQ_WIDTH-1:0] mask_r;
  logic stop_r;
  logic [31:0] prdata_r;

  // Staging bytes hold partial values so nothing half-written is ever used
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sla_hi_r <= 4'h0;
      sla_mid_r <= 8'h00;
      cwp_hi_r <= 4'h0;
      cwp_mid_r <= 8'h00;
      crp_hi_r <= 4'h0;
      crp_mid_r <= 8'h00;
      rbc_hi_r <= 3'h0;
      fr_hi_r <= 3'h0;
      tmr_hi_r <= 8'h00;
    end
    else
    begin
      if (w_sla_hi) sla_hi_r <= wb[3:0];
      if (w_sla_mid) sla_mid_r <= wb;
      if (w_cwp_hi) cwp_hi_r <= wb[3:0];
      if (w_cwp_mid) cwp_mid_r <= wb;
      if (w_crp_hi) crp_hi_r <= wb[3:0];
      if (w_crp_mid) crp_mid_r <= wb;
      if (w_rbc_hi) rbc_hi_r <= wb[2:0];
      if (w_fr_hi) fr_hi_r <= wb[2:0];
      if (w_tmr_hi) tmr_hi_r <= wb;
    end
  end

  // ****************************************
  // Address pointers
  // ****************************************
  wire logic [19:0] cwp_nxt = w_cwp_lo ? {cwp_hi_r, cwp_mid_r, wb} :
                              cpu_buf_write ? inc20(cwp_r) : cwp_r;
  wire logic [19:0] crp_nxt = w_crp_lo ? {crp_hi_r, crp_mid_r, wb} :
                              cpu_buf_read ? inc20(crp_r) : crp_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sla_r <= 20'h00000;
      cwp_r <= 20'h00000;
      crp_r <= 20'h00000;
      fr_r <= 11'h000;
      scale_r <= `BPTR_RESET_BYTE;
      ctrl_r <= 2'b00;
      blk_inc_r <= 2'b00;
      mask_r <= '0;
    end
    else
    begin
      if (w_sla_lo) sla_r <= {sla_hi_r, sla_mid_r, wb};
      cwp_r <= cwp_nxt;
      crp_r <= crp_nxt;
      if (w_fr_lo) fr_r <= {fr_hi_r, wb};
      if (w_scale) scale_r <= wb;
      if (w_ctrl) ctrl_r <= wb[1:0];
      if (w_inc) blk_inc_r <= wb[1:0];
      if (w_mask) mask_r <= wb[`BPTR_IRQ_WIDTH-1:0];
    end
  end

  // ****************************************
  // Subcode end limit
  // ****************************************
  wire logic end_limit_enable = ctrl_r[`BPTR_CTRL_END_LIMIT_BIT];
  wire logic subcode_mode = ctrl_r[`BPTR_CTRL_SUBCODE_BIT];
  wire logic limit_hit = buf_write && subcode_mode && end_limit_enable && (buf_write_addr == sla_r);
  // Leaving subcode mode releases the stop
  wire logic stop_nxt = limit_hit || (stop_r && subcode_mode);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) stop_r <= 1'b0;
    else stop_r <= stop_nxt;
  end

  // ****************************************
  // Ready block count
  // ****************************************
  wire logic [9:0] step = {8'h00, blk_inc_r} + 10'h001;
  wire logic add_blk = sector_done && sector_transfer_flag && !stop_r;
  // Reads are not synchronised with updates; software accepts one count of skew
  wire logic [9:0] rbc_nxt = w_rbc_lo ? {rbc_hi_r[1:0], wb} :
                             rbc_r + (add_blk ? step : 10'h000)
                             - (block_xfer_done ? 10'h001 : 10'h000);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) rbc_r <= 10'h000;
    else rbc_r <= rbc_nxt;
  end

  // ****************************************
  // One-shot timer
  // ****************************************
  bptr_tmr_state_t tmr_state_r;
  logic [11:0] tick_r;
  logic [7:0] res_r;
  logic [15:0] remain_r;
  wire logic tick_end = (tick_r == `BPTR_TICKS_PER_STEP - 12'h001);
  wire logic res_end = tick_end && (res_r == scale_r - 8'h01);
  wire logic zero_len = (wb == 8'h00 && tmr_hi_r == 8'h00) || scale_r == 8'h00;
  wire logic tmr_fire = (tmr_state_r == BPTR_TMR_RUN) && res_end && (remain_r == 16'h0001);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tmr_state_r <= BPTR_TMR_IDLE;
      tick_r <= 12'h000;
      res_r <= 8'h00;
      remain_r <= 16'h0000;
      tmr_r <= 16'h0000;
    end
    else
    begin
      case (tmr_state_r)
        BPTR_TMR_IDLE:
        begin
          if (w_tmr_lo && !zero_len)
          begin
            tmr_state_r <= BPTR_TMR_RUN;
            remain_r <= {tmr_hi_r, wb};
          end
        end
        BPTR_TMR_RUN:
        begin
          if (w_tmr_lo)
          begin
            tmr_state_r <= zero_len ? BPTR_TMR_IDLE : BPTR_TMR_RUN;
            remain_r <= {tmr_hi_r, wb};
          end
          else if (tmr_fire) tmr_state_r <= BPTR_TMR_IDLE;
          else if (res_end) remain_r <= remain_r - 16'h0001;
        end
        default: tmr_state_r <= BPTR_TMR_IDLE;
      endcase
      if (w_tmr_lo || tmr_state_r != BPTR_TMR_RUN || res_end)
      begin
        tick_r <= 12'h000;
        res_r <= 8'h00;
      end
      else if (tick_end)
      begin
        tick_r <= 12'h000;
        res_r <= res_r + 8'h01;
      end
      else tick_r <= tick_r + 12'h001;
      if (w_tmr_lo) tmr_r <= {tmr_hi_r, wb};
    end
  end

  // ****************************************
  // Interrupt status
  // ****************************************
  logic [`BPTR_IRQ_WIDTH-1:0] ev;
  assign ev = {limit_hit, tmr_fire};
  wire logic [`BPTR_IRQ_WIDTH-1:0] clr = w_stat ? wb[`BPTR_IRQ_WIDTH-1:0] : '0;

  // Set wins over a simultaneous clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) stat_r <= '0;
    else stat_r <= (stat_r & ~clr) | ev;
  end

  // ****************************************
  // Read mux
  // ****************************************
  logic [7:0] rd_byte;
  logic rd_ok;
  always_comb
  begin
    rd_byte = 8'h00;
    rd_ok = aligned;
    case (idx)
      `BPTR_IDX_SLA_HI: rd_byte = {4'h0, sla_r[19:16]};
      `BPTR_IDX_SLA_MID: rd_byte = sla_r[15:8];
      `BPTR_IDX_SLA_LO: rd_byte = sla_r[7:0];
      `BPTR_IDX_CWP_HI: rd_byte = {4'h0, cwp_r[19:16]};
      `BPTR_IDX_CWP_MID: rd_byte = cwp_r[15:8];
      `BPTR_IDX_CWP_LO: rd_byte = cwp_r[7:0];
      `BPTR_IDX_CRP_HI: rd_byte = {4'h0, crp_r[19:16]};
      `BPTR_IDX_CRP_MID: rd_byte = crp_r[15:8];
      `BPTR_IDX_CRP_LO: rd_byte = crp_r[7:0];
      `BPTR_IDX_RBC_HI: rd_byte = {6'h00, rbc_r[9:8]};
      `BPTR_IDX_RBC_LO: rd_byte = rbc_r[7:0];
      `BPTR_IDX_FR_HI: rd_byte = {5'h00, fr_r[10:8]};
      `BPTR_IDX_FR_LO: rd_byte = fr_r[7:0];
      `BPTR_IDX_TMR_HI: rd_byte = tmr_r[15:8];
      `BPTR_IDX_TMR_LO: rd_byte = tmr_r[7:0];
      `BPTR_IDX_TSCALE: rd_byte = scale_r;
      `BPTR_IDX_SBA_HI: rd_byte = {7'h00, stream_begin_area[8]};
      `BPTR_IDX_SBA_LO: rd_byte = stream_begin_area[7:0];
      `BPTR_IDX_CTRL: rd_byte = {5'h00, stop_r, ctrl_r};
      `BPTR_IDX_IRQ_STAT: rd_byte = {6'h00, stat_r};
      `BPTR_IDX_IRQ_MASK: rd_byte = {6'h00, mask_r};
      `BPTR_IDX_BLK_INC: rd_byte = {6'h00, blk_inc_r};
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) prdata_r <= 32'h00000000;
    else if (psel && !penable && !pwrite) prdata_r <= {24'h000000, rd_byte};
  end

  // Zero-wait slave; read data captured in setup phase
  assign pready = 1'b1;
  assign pslverr = access && !rd_ok;
  assign prdata = prdata_r;
  assign cpu_write_ptr = cwp_r;
  assign cpu_read_ptr = crp_r;
  assign fill_ratio = fr_r;
  assign buffering_stop = stop_r;
  assign irq = |(stat_r & mask_r);

  // ****************************************
  // Checks
  // ****************************************
  chk_write_ptr_inc: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_buf_write && !w_cwp_lo |=> cwp_r == $past(cwp_r) + 20'h00001)
    else $error("write pointer did not advance");
  chk_read_ptr_inc: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_buf_read && !w_crp_lo |=> crp_r == $past(crp_r) + 20'h00001)
    else $error("read pointer did not advance");
  chk_block_dec: assert property (@(posedge pclk) disable iff (!presetn)
    block_xfer_done && !add_blk && !w_rbc_lo |=> rbc_r == $past(rbc_r) - 10'h001)
    else $error("block count not decremented by one");
  chk_block_inc: assert property (@(posedge pclk) disable iff (!presetn)
    add_blk && !block_xfer_done && !w_rbc_lo |=> rbc_r == $past(rbc_r) + {8'h00, $past(blk_inc_r)} + 10'h001)
    else $error("block count increment wrong");
  chk_limit_stop: assert property (@(posedge pclk) disable iff (!presetn)
    limit_hit |=> buffering_stop && stat_r[`BPTR_IRQ_STOP_BIT])
    else $error("end limit did not stop buffering");
  chk_ratio_load: assert property (@(posedge pclk) disable iff (!presetn)
    w_fr_lo |=> fill_ratio == {$past(fr_hi_r), $past(wb)})
    else $error("fill ratio load wrong");
  chk_slast_atomic: assert property (@(posedge pclk) disable iff (!presetn)
    !w_sla_lo |=> $stable(sla_r))
    else $error("last address changed without low write");
  chk_timer_oneshot: assert property (@(posedge pclk) disable iff (!presetn)
    tmr_fire && !w_tmr_lo |=> tmr_state_r == BPTR_TMR_IDLE && !tmr_fire)
    else $error("timer did not return to idle");
  chk_timer_unit: assert property (@(posedge pclk) disable iff (!presetn)
    w_tmr_lo && !zero_len && scale_r == 8'h01 && tmr_hi_r == 8'h00 && wb == 8'h01 && !w_scale
    |=> !tmr_fire [*8] ##1 !tmr_fire [*7] ##1 tmr_fire)
    else $error("timer period not sixteen cycles per unit");
  cov_timer_fire: cover property (@(posedge pclk) disable iff (!presetn) tmr_fire);
  cov_limit: cover property (@(posedge pclk) disable iff (!presetn) limit_hit);
  cov_both_blk: cover property (@(posedge pclk) disable iff (!presetn) add_blk && block_xfer_done);
  cov_irq: cover property (@(posedge pclk) disable iff (!presetn) irq);

endmodule

// [bptr_regs_tb_top.sv]
// Self-checking bench for the buffer pointer and timer register bank.
// Assumes bptr_params.svh on the include path and a zero-wait APB slave.
`timescale 1ns/1ps
`include "bptr_params.svh"

module bptr_regs_tb_top
  import bptr_pkg::*;
;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cpu_buf_write;
  logic cpu_buf_read;
  logic buf_write;
  logic [19:0] buf_write_addr;
  logic sector_done;
  logic sector_transfer_flag;
  logic block_xfer_done;
  logic [8:0] stream_begin_area;
  logic [19:0] cpu_write_ptr;
  logic [19:0] cpu_read_ptr;
  logic [10:0] fill_ratio;
  logic buffering_stop;
  logic irq;
  int err_count = 0;
  int tests_run = 0;

  bptr_regs i_bptr_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_buf_write(cpu_buf_write), .cpu_buf_read(cpu_buf_read), .buf_write(buf_write),
    .buf_write_addr(buf_write_addr), .sector_done(sector_done), .sector_transfer_flag(sector_transfer_flag),
    .block_xfer_done(block_xfer_done), .stream_begin_area(stream_begin_area), .cpu_write_ptr(cpu_write_ptr),
    .cpu_read_ptr(cpu_read_ptr), .fill_ratio(fill_ratio), .buffering_stop(buffering_stop), .irq(irq));

  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask

  // Request held until pready is sampled high; a stuck slave ends the run
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd,
    output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16)
    begin
      @(posedge pclk);
      n++;
    end
    if (n == 16)
    begin
      $display("CHECK FAILED pready expected 1 seen %b", pready);
      err_count++;
      end_of_test();
    end
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [7:0] r;
    logic e;
    apb(1'b1, idx, wd, r, e);
  endtask

  task automatic rd(input string name, input logic [7:0] idx, input logic [7:0] exp, input logic exp_err = 1'b0);
    logic [7:0] r;
    logic e;
    apb(1'b0, idx, 8'h00, r, e);
    chk(name, {23'h000000, exp_err, exp}, {23'h000000, e, r});
  endtask

  // One-cycle event pulse, taken at the first edge after it is raised
  task automatic ev(input int k);
    @(posedge pclk);
    case (k)
      0: cpu_buf_write <= 1'b1;
      1: cpu_buf_read <= 1'b1;
      2: buf_write <= 1'b1;
      3: sector_done <= 1'b1;
      default: block_xfer_done <= 1'b1;
    endcase
    @(posedge pclk);
    cpu_buf_write <= 1'b0;
    cpu_buf_read <= 1'b0;
    buf_write <= 1'b0;
    sector_done <= 1'b0;
    block_xfer_done <= 1'b0;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    logic [9:0] cnt;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {cpu_buf_write, cpu_buf_read, buf_write, sector_done, sector_transfer_flag, block_xfer_done} = '0;
    buf_write_addr = 20'h00000;
    stream_begin_area = 9'h1a5;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd("wptr_hi_reset", `BPTR_IDX_CWP_HI, 8'h00);
    rd("tscale_reset", `BPTR_IDX_TSCALE, 8'h00);
    // Pointers: partial loads must not leak out
    wr(`BPTR_IDX_CWP_HI, 8'h0a);
    wr(`BPTR_IDX_CWP_MID, 8'hbc);
    #1 chk("wptr_partial", 32'h00000, cpu_write_ptr);
    wr(`BPTR_IDX_CWP_LO, 8'hde);
    #1 chk("wptr_load", 32'habcde, cpu_write_ptr);
    repeat (3) ev(0);
    #1 chk("wptr_inc", 32'habce1, cpu_write_ptr);
    rd("wptr_lo", `BPTR_IDX_CWP_LO, 8'he1);
    wr(`BPTR_IDX_CRP_HI, 8'h0f);
    wr(`BPTR_IDX_CRP_MID, 8'hff);
    wr(`BPTR_IDX_CRP_LO, 8'hff);
    repeat (2) ev(1);
    #1 chk("rptr_wrap", 32'h00001, cpu_read_ptr);
    // Block count: every increment setting, then one transfer
    wr(`BPTR_IDX_RBC_HI, 8'h01);
    wr(`BPTR_IDX_RBC_LO, 8'h02);
    cnt = 10'h102;
    for (int k = 0; k < 4; k++)
    begin
      wr(`BPTR_IDX_BLK_INC, k[7:0]);
      sector_transfer_flag <= 1'b1;
      ev(3);
      cnt = cnt + 10'(k + 1);
    end
    sector_transfer_flag <= 1'b0;
    ev(3);
    ev(4);
    cnt = cnt - 10'h001;
    rd("blk_lo", `BPTR_IDX_RBC_LO, cnt[7:0]);
    rd("blk_hi", `BPTR_IDX_RBC_HI, {6'h00, cnt[9:8]});
    // Fill ratio and read-only start area
    wr(`BPTR_IDX_FR_HI, 8'h07);
    wr(`BPTR_IDX_FR_LO, 8'hff);
    #1 chk("fill_ratio", 32'h7ff, fill_ratio);
    rd("fill_hi", `BPTR_IDX_FR_HI, 8'h07);
    rd("area_hi", `BPTR_IDX_SBA_HI, 8'h01);
    wr(`BPTR_IDX_SBA_LO, 8'h00);
    rd("area_lo", `BPTR_IDX_SBA_LO, 8'ha5);
    rd("unmapped", 8'h50, 8'h00, 1'b1);
    // Timer: 3 steps of scale 2 gives 96 cycles
    wr(`BPTR_IDX_IRQ_MASK, 8'h03);
    wr(`BPTR_IDX_TSCALE, 8'h02);
    wr(`BPTR_IDX_TMR_HI, 8'h00);
    wr(`BPTR_IDX_TMR_LO, 8'h03);
    repeat (95) @(posedge pclk);
    #1 chk("irq_early", 32'h0, irq);
    @(posedge pclk);
    #1 chk("irq_timer", 32'h1, irq);
    rd("stat_timer", `BPTR_IDX_IRQ_STAT, 8'h01);
    wr(`BPTR_IDX_IRQ_STAT, 8'h01);
    repeat (200) @(posedge pclk);
    #1 chk("irq_oneshot", 32'h0, irq);
    // Unit period: scale 1, count 1 fires after sixteen cycles
    wr(`BPTR_IDX_TSCALE, 8'h01);
    wr(`BPTR_IDX_TMR_LO, 8'h01);
    repeat (15) @(posedge pclk);
    #1 chk("irq_unit_early", 32'h0, irq);
    @(posedge pclk);
    #1 chk("irq_unit", 32'h1, irq);
    rd("tmr_lo", `BPTR_IDX_TMR_LO, 8'h01);
    wr(`BPTR_IDX_IRQ_STAT, 8'h01);
    // End limit at subcode last address 0x00100
    wr(`BPTR_IDX_SLA_HI, 8'h00);
    wr(`BPTR_IDX_SLA_MID, 8'h01);
    wr(`BPTR_IDX_SLA_LO, 8'h00);
    wr(`BPTR_IDX_CTRL, 8'h03);
    buf_write_addr <= 20'h000ff;
    ev(2);
    @(posedge pclk);
    buf_write_addr <= 20'h00100;
    #1 chk("stop_before", 32'h0, buffering_stop);
    ev(2);
    @(posedge pclk);
    #1 chk("stop_at_last", 32'h1, buffering_stop);
    chk("irq_stop", 32'h1, irq);
    rd("stat_stop", `BPTR_IDX_IRQ_STAT, 8'h02);
    wr(`BPTR_IDX_BLK_INC, 8'h00);
    sector_transfer_flag <= 1'b1;
    ev(3);
    rd("blk_stopped", `BPTR_IDX_RBC_LO, cnt[7:0]);
    wr(`BPTR_IDX_CTRL, 8'h02);
    @(posedge pclk);
    #1 chk("stop_release", 32'h0, buffering_stop);
    // Stop status stays sticky; masking hides it, writing one clears it
    wr(`BPTR_IDX_IRQ_MASK, 8'h01);
    #1 chk("irq_masked", 32'h0, irq);
    wr(`BPTR_IDX_IRQ_STAT, 8'h02);
    rd("stat_clear", `BPTR_IDX_IRQ_STAT, 8'h00);
    end_of_test();
  end
endmodule
